// ==== rtl/ccw_params.svh ====
// Register map, field layout and reset values of the coefficient weighting block.
// Assumes inclusion by bare name from design files.
`ifndef CCW_PARAMS_SVH
`define CCW_PARAMS_SVH
`define CCW_OFS_CIM0       8'h12
`define CCW_OFS_CIM1       8'h13
`define CCW_OFS_CIM2       8'h14
`define CCW_OFS_CIM3       8'h15
`define CCW_OFS_CRE0       8'h16
`define CCW_OFS_CRE1       8'h17
`define CCW_OFS_CRE2       8'h18
`define CCW_OFS_CRE3       8'h19
`define CCW_OFS_FIM0       8'h1a
`define CCW_OFS_FIM1       8'h1b
`define CCW_OFS_FIM2       8'h1c
`define CCW_OFS_FIM3       8'h1d
`define CCW_OFS_FRE0       8'h1e
`define CCW_OFS_FRE1       8'h1f
`define CCW_OFS_FRE2       8'h20
`define CCW_OFS_FRE3       8'h21
`define CCW_OFS_FIRST      8'h12
`define CCW_OFS_LAST       8'h21
`define CCW_OFS_STATUS     8'h30
`define CCW_WEIGHT_RESET   16'h0000
`define CCW_FRAC_BITS      14
`define CCW_UNMAPPED_READ  32'h0000_0000
`endif

// ==== rtl/ccw_pkg.sv ====
// Types shared by the coefficient weighting block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package ccw_pkg;
	typedef logic signed [15:0] ccw_weight_t;
	typedef enum logic [1:0] {
		CCW_IDLE,
		CCW_RESP
	} ccw_bus_state_t;
endpackage : ccw_pkg
`default_nettype wire

// ==== rtl/ccw_weighting.sv ====
// Clarke coefficient weighting: sixteen Q2.14 weights, coarse and fine paths.
// Assumes synchronous channel samples with a valid strobe, and an Avalon-MM master.
`include "ccw_params.svh"
`default_nettype none
module ccw_weighting #(
	parameter int SAMPLE_W = 16,
	parameter int ACC_W    = 34
) (
	input  wire logic                       ref_clk,
	input  wire logic                       reset,
	input  wire logic [7:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output var  logic [31:0]                avs_readdata,
	output var  logic                       avs_waitrequest,
	output var  logic [1:0]                 avs_response,
	input  wire logic                       in_valid,
	input  wire logic signed [SAMPLE_W-1:0] coarse_ch0,
	input  wire logic signed [SAMPLE_W-1:0] coarse_ch1,
	input  wire logic signed [SAMPLE_W-1:0] coarse_ch2,
	input  wire logic signed [SAMPLE_W-1:0] coarse_ch3,
	input  wire logic signed [SAMPLE_W-1:0] fine_ch0,
	input  wire logic signed [SAMPLE_W-1:0] fine_ch1,
	input  wire logic signed [SAMPLE_W-1:0] fine_ch2,
	input  wire logic signed [SAMPLE_W-1:0] fine_ch3,
	output var  logic                       out_valid,
	output var  logic signed [ACC_W-1:0]    coarse_real,
	output var  logic signed [ACC_W-1:0]    coarse_imag,
	output var  logic signed [ACC_W-1:0]    fine_real,
	output var  logic signed [ACC_W-1:0]    fine_imag
);
	localparam int PROD_W = SAMPLE_W + 16;

	// Index 0..15 follows the map order: cim0..3, cre0..3, fim0..3, fre0..3
	ccw_pkg::ccw_weight_t weight_r [16];
	ccw_pkg::ccw_bus_state_t bus_state_r;
	logic [15:0] write_count_r;

	wire       in_range = (avs_address >= `CCW_OFS_FIRST) && (avs_address <= `CCW_OFS_LAST);
	wire [3:0] widx     = 4'(avs_address - `CCW_OFS_FIRST);
	wire       is_stat  = (avs_address == `CCW_OFS_STATUS);
	wire       req      = (avs_read || avs_write) && (bus_state_r == ccw_pkg::CCW_IDLE);
	wire       wr_hit   = req && avs_write && in_range;
	wire [15:0] wmask   = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire [15:0] wr_val  = (weight_r[widx] & ~wmask) | (avs_writedata[15:0] & wmask);
	wire [31:0] rd_val  = in_range ? {16'h0000, weight_r[widx]} :
	                      is_stat  ? {16'h0000, write_count_r} : `CCW_UNMAPPED_READ;
	// Unmapped accesses complete with a slave-error response rather than hanging the bus
	wire [1:0]  rd_resp = (in_range || is_stat) ? 2'b00 : 2'b10;
	wire [1:0]  wr_resp = in_range ? 2'b00 : 2'b10;

	// One wait state: request seen in IDLE, answered with waitrequest low in RESP
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			bus_state_r <= ccw_pkg::CCW_IDLE;
		end else begin
			case (bus_state_r)
				ccw_pkg::CCW_IDLE: bus_state_r <= req ? ccw_pkg::CCW_RESP : ccw_pkg::CCW_IDLE;
				ccw_pkg::CCW_RESP: bus_state_r <= ccw_pkg::CCW_IDLE;
				default:           bus_state_r <= ccw_pkg::CCW_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			avs_response    <= 2'b00;
		end else begin
			avs_waitrequest <= ~req;
			if (req) begin
				avs_readdata <= avs_read ? rd_val : 32'h0000_0000;
				avs_response <= avs_read ? rd_resp : wr_resp;
			end
		end
	end

	// Weights written in the request cycle; the answer follows one edge later
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			for (int i = 0; i < 16; i++) begin
				weight_r[i] <= `CCW_WEIGHT_RESET;
			end
			write_count_r <= 16'h0000;
		end else if (wr_hit) begin
			weight_r[widx] <= wr_val;
			write_count_r  <= write_count_r + 16'h0001;
		end
	end

	// Full-precision signed products; Q2.14 weights leave 14 fraction bits in each product
	wire signed [PROD_W-1:0] p_cim0 = coarse_ch0 * weight_r[0];
	wire signed [PROD_W-1:0] p_cim1 = coarse_ch1 * weight_r[1];
	wire signed [PROD_W-1:0] p_cim2 = coarse_ch2 * weight_r[2];
	wire signed [PROD_W-1:0] p_cim3 = coarse_ch3 * weight_r[3];
	wire signed [PROD_W-1:0] p_cre0 = coarse_ch0 * weight_r[4];
	wire signed [PROD_W-1:0] p_cre1 = coarse_ch1 * weight_r[5];
	wire signed [PROD_W-1:0] p_cre2 = coarse_ch2 * weight_r[6];
	wire signed [PROD_W-1:0] p_cre3 = coarse_ch3 * weight_r[7];
	wire signed [PROD_W-1:0] p_fim0 = fine_ch0 * weight_r[8];
	wire signed [PROD_W-1:0] p_fim1 = fine_ch1 * weight_r[9];
	wire signed [PROD_W-1:0] p_fim2 = fine_ch2 * weight_r[10];
	wire signed [PROD_W-1:0] p_fim3 = fine_ch3 * weight_r[11];
	wire signed [PROD_W-1:0] p_fre0 = fine_ch0 * weight_r[12];
	wire signed [PROD_W-1:0] p_fre1 = fine_ch1 * weight_r[13];
	wire signed [PROD_W-1:0] p_fre2 = fine_ch2 * weight_r[14];
	wire signed [PROD_W-1:0] p_fre3 = fine_ch3 * weight_r[15];

	// ACC_W keeps two guard bits so the four-term sum never wraps
	wire signed [ACC_W-1:0] sum_cre = ACC_W'(p_cre0) + ACC_W'(p_cre1)
	                                + ACC_W'(p_cre2) + ACC_W'(p_cre3);
	wire signed [ACC_W-1:0] sum_cim = ACC_W'(p_cim0) + ACC_W'(p_cim1)
	                                + ACC_W'(p_cim2) + ACC_W'(p_cim3);
	wire signed [ACC_W-1:0] sum_fre = ACC_W'(p_fre0) + ACC_W'(p_fre1)
	                                + ACC_W'(p_fre2) + ACC_W'(p_fre3);
	wire signed [ACC_W-1:0] sum_fim = ACC_W'(p_fim0) + ACC_W'(p_fim1)
	                                + ACC_W'(p_fim2) + ACC_W'(p_fim3);

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			out_valid   <= 1'b0;
			coarse_real <= '0;
			coarse_imag <= '0;
			fine_real   <= '0;
			fine_imag   <= '0;
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				coarse_real <= sum_cre;
				coarse_imag <= sum_cim;
				fine_real   <= sum_fre;
				fine_imag   <= sum_fim;
			end
		end
	end

	// Assertion helpers: one-cycle-old samples used to recompute expectations
	logic signed [SAMPLE_W-1:0] c0_q, c1_q, c2_q, c3_q, f0_q, f1_q, f2_q, f3_q;
	always_ff @(posedge ref_clk) begin
		c0_q <= coarse_ch0;
		c1_q <= coarse_ch1;
		c2_q <= coarse_ch2;
		c3_q <= coarse_ch3;
		f0_q <= fine_ch0;
		f1_q <= fine_ch1;
		f2_q <= fine_ch2;
		f3_q <= fine_ch3;
	end

	sequence s_bus_req;
		(avs_read || avs_write) && avs_waitrequest && bus_state_r == ccw_pkg::CCW_IDLE;
	endsequence
	sequence s_bus_ans;
		!avs_waitrequest;
	endsequence

	a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (reset)
		s_bus_req |=> s_bus_ans ##1 avs_waitrequest)
		else $error("bus answer not exactly one cycle after request");
	a_weight_reset_zero: assert property (@(posedge ref_clk)
		$past(reset) && !reset |-> weight_r[7] == 16'h0000 && weight_r[9] == 16'h0000
		&& weight_r[0] == 16'h0000 && weight_r[15] == 16'h0000)
		else $error("weight not zero after reset");
	a_coarse_re1_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h17 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[5] == $past(avs_writedata[15:0]))
		else $error("coarse real weight ch1 not stored");
	a_coarse_re2_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h18 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[6] == $past(avs_writedata[15:0]))
		else $error("coarse real weight ch2 not stored");
	a_coarse_re3_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h19
		|=> !avs_waitrequest && avs_readdata == {16'h0000, $past(weight_r[7])})
		else $error("coarse real weight ch3 readback wrong");
	a_fine_im_sum: assert property (@(posedge ref_clk) disable iff (reset)
		in_valid |=> fine_imag == ACC_W'(f0_q) * ACC_W'($past(weight_r[8]))
		                        + ACC_W'(f1_q) * ACC_W'($past(weight_r[9]))
		                        + ACC_W'(f2_q) * ACC_W'($past(weight_r[10]))
		                        + ACC_W'(f3_q) * ACC_W'($past(weight_r[11])))
		else $error("fine imaginary sum wrong");
	a_fine_re_sum: assert property (@(posedge ref_clk) disable iff (reset)
		in_valid |=> fine_real == ACC_W'(f0_q) * ACC_W'($past(weight_r[12]))
		                        + ACC_W'(f1_q) * ACC_W'($past(weight_r[13]))
		                        + ACC_W'(f2_q) * ACC_W'($past(weight_r[14]))
		                        + ACC_W'(f3_q) * ACC_W'($past(weight_r[15])))
		else $error("fine real sum wrong");
	a_unity_weight: assert property (@(posedge ref_clk) disable iff (reset)
		in_valid && weight_r[5] == 16'h4000 && weight_r[4] == 16'h0000
		&& weight_r[6] == 16'h0000 && weight_r[7] == 16'h0000
		|=> coarse_real == (ACC_W'(c1_q) <<< `CCW_FRAC_BITS))
		else $error("unity Q2.14 weight does not pass channel");
	a_out_valid_lag: assert property (@(posedge ref_clk) disable iff (reset)
		in_valid ##1 !in_valid |-> out_valid ##1 !out_valid)
		else $error("output strobe not one cycle behind input");
	a_hold_no_valid: assert property (@(posedge ref_clk) disable iff (reset)
		!in_valid |=> !out_valid && $stable(coarse_real) && $stable(coarse_imag)
		&& $stable(fine_real) && $stable(fine_imag))
		else $error("outputs changed without valid sample");
	a_unmapped_error: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h11 |=> avs_response == 2'b10)
		else $error("unmapped read not flagged");

	// Each map entry: a full-lane write lands at the taking edge
	a_coarse_im0_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h12 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[0] == $past(avs_writedata[15:0]))
		else $error("coarse imaginary weight ch0 not stored");
	a_coarse_im1_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h13 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[1] == $past(avs_writedata[15:0]))
		else $error("coarse imaginary weight ch1 not stored");
	a_coarse_im2_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h14 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[2] == $past(avs_writedata[15:0]))
		else $error("coarse imaginary weight ch2 not stored");
	a_coarse_im3_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h15 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[3] == $past(avs_writedata[15:0]))
		else $error("coarse imaginary weight ch3 not stored");
	a_coarse_re0_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h16 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[4] == $past(avs_writedata[15:0]))
		else $error("coarse real weight ch0 not stored");
	a_coarse_re3_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h19 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[7] == $past(avs_writedata[15:0]))
		else $error("coarse real weight ch3 not stored");
	a_fine_im0_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1a && avs_byteenable[1:0] == 2'b11
		|=> weight_r[8] == $past(avs_writedata[15:0]))
		else $error("fine imaginary weight ch0 not stored");
	a_fine_im1_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1b && avs_byteenable[1:0] == 2'b11
		|=> weight_r[9] == $past(avs_writedata[15:0]))
		else $error("fine imaginary weight ch1 not stored");
	a_fine_im2_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1c && avs_byteenable[1:0] == 2'b11
		|=> weight_r[10] == $past(avs_writedata[15:0]))
		else $error("fine imaginary weight ch2 not stored");
	a_fine_im3_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1d && avs_byteenable[1:0] == 2'b11
		|=> weight_r[11] == $past(avs_writedata[15:0]))
		else $error("fine imaginary weight ch3 not stored");
	a_fine_re0_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1e && avs_byteenable[1:0] == 2'b11
		|=> weight_r[12] == $past(avs_writedata[15:0]))
		else $error("fine real weight ch0 not stored");
	a_fine_re1_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1f && avs_byteenable[1:0] == 2'b11
		|=> weight_r[13] == $past(avs_writedata[15:0]))
		else $error("fine real weight ch1 not stored");
	a_fine_re2_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h20 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[14] == $past(avs_writedata[15:0]))
		else $error("fine real weight ch2 not stored");
	a_fine_re3_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h21 && avs_byteenable[1:0] == 2'b11
		|=> weight_r[15] == $past(avs_writedata[15:0]))
		else $error("fine real weight ch3 not stored");

	// Readback stands with the answer; mapped words answer okay
	a_coarse_im0_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h12
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[0])})
		else $error("coarse imaginary weight ch0 readback wrong");
	a_coarse_re1_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h17
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[5])})
		else $error("coarse real weight ch1 readback wrong");
	a_fine_im0_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h1a
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[8])})
		else $error("fine imaginary weight ch0 readback wrong");
	a_fine_im1_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h1b
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[9])})
		else $error("fine imaginary weight ch1 readback wrong");
	a_fine_re0_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h1e
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[12])})
		else $error("fine real weight ch0 readback wrong");
	a_fine_re1_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h1f
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[13])})
		else $error("fine real weight ch1 readback wrong");
	a_fine_re2_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h20
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(weight_r[14])})
		else $error("fine real weight ch2 readback wrong");
	a_status_read: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_read && avs_address == 8'h30
		|=> avs_response == 2'b00 && avs_readdata == {16'h0000, $past(write_count_r)})
		else $error("status readback wrong");

	a_coarse_re_sum: assert property (
		@(posedge ref_clk) disable iff (reset)
		in_valid |=> coarse_real == ACC_W'(c0_q) * ACC_W'($past(weight_r[4]))
		                          + ACC_W'(c1_q) * ACC_W'($past(weight_r[5]))
		                          + ACC_W'(c2_q) * ACC_W'($past(weight_r[6]))
		                          + ACC_W'(c3_q) * ACC_W'($past(weight_r[7])))
		else $error("coarse real sum wrong");
	a_coarse_im_sum: assert property (
		@(posedge ref_clk) disable iff (reset)
		in_valid |=> coarse_imag == ACC_W'(c0_q) * ACC_W'($past(weight_r[0]))
		                          + ACC_W'(c1_q) * ACC_W'($past(weight_r[1]))
		                          + ACC_W'(c2_q) * ACC_W'($past(weight_r[2]))
		                          + ACC_W'(c3_q) * ACC_W'($past(weight_r[3])))
		else $error("coarse imaginary sum wrong");

	a_low_lane_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h12 && avs_byteenable[1:0] == 2'b01
		|=> weight_r[0][7:0] == $past(avs_writedata[7:0])
		&& weight_r[0][15:8] == $past(weight_r[0][15:8]))
		else $error("byte lane 0 write wrong");
	a_unmapped_write: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h11
		|=> avs_response == 2'b10 && $stable(weight_r[15]) && $stable(write_count_r))
		else $error("unmapped write not refused");
	a_status_count: assert property (@(posedge ref_clk) disable iff (reset)
		req && avs_write && avs_address == 8'h1f
		|=> write_count_r == $past(write_count_r) + 16'h0001)
		else $error("accepted write not counted");
	a_reset_outputs: assert property (@(posedge ref_clk)
		$past(reset) && !reset |-> avs_waitrequest && !out_valid
		&& coarse_real == '0 && coarse_imag == '0 && fine_real == '0 && fine_imag == '0)
		else $error("outputs not cleared by reset");
endmodule : ccw_weighting
`default_nettype wire

// ==== tb/ccw_chan_src.sv ====
// Upstream filter/rectifier model: one set of eight samples per start pulse.
// Assumes start is a one-cycle pulse driven just after a rising edge.
`default_nettype none
module ccw_chan_src (
	input  wire logic               ref_clk,
	input  wire logic               reset,
	input  wire logic               start,
	input  wire logic               neg,
	output var  logic               in_valid,
	output var  logic signed [15:0] smp [8]
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		in_valid = 1'b0;
		smp      = '{default: 16'h0000};
	end
	always @(posedge ref_clk) begin
		in_valid <= start & !reset;
		for (int i = 0; i < 8; i++) begin
			// Stale lines toggle so an old sample never passes for a fresh one
			smp[i] <= start ? 16'((i + 1) * 1000 * (neg ? -1 : 1)) : ~smp[i];
		end
	end
endmodule : ccw_chan_src
`default_nettype wire

// ==== tb/tb_ccw_weighting.sv ====
// Self-checking bench: Avalon-MM register tasks and sample sequences.
// Assumes the design answers each bus request with one low waitrequest cycle.
`default_nettype none
module tb_ccw_weighting;
	timeunit 1ns;
	timeprecision 1ps;
	logic               ref_clk       = 1'b0;
	logic               reset         = 1'b1;
	logic [7:0]         avs_address   = 8'h00;
	logic               avs_read      = 1'b0;
	logic               avs_write     = 1'b0;
	logic [31:0]        avs_writedata = 32'h0000_0000;
	logic               start         = 1'b0;
	logic               neg           = 1'b0;
	logic [3:0]         be            = 4'hf;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic [1:0]         avs_response;
	logic               in_valid;
	logic               out_valid;
	logic signed [15:0] smp [8];
	logic signed [33:0] coarse_real, coarse_imag, fine_real, fine_imag;
	logic signed [15:0] w [16];
	logic [31:0]        rd;
	logic [1:0]         rs;
	int                 error_cnt    = 0;
	int                 total_checks = 0;
	always #5 ref_clk = ~ref_clk;
	ccw_chan_src u_ccw_chan_src (.ref_clk(ref_clk), .reset(reset), .start(start), .neg(neg),
		.in_valid(in_valid), .smp(smp));
	ccw_weighting u_ccw_weighting (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(be), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.avs_response(avs_response), .in_valid(in_valid), .coarse_ch0(smp[0]),
		.coarse_ch1(smp[1]), .coarse_ch2(smp[2]), .coarse_ch3(smp[3]), .fine_ch0(smp[4]),
		.fine_ch1(smp[5]), .fine_ch2(smp[6]), .fine_ch3(smp[7]), .out_valid(out_valid),
		.coarse_real(coarse_real), .coarse_imag(coarse_imag), .fine_real(fine_real),
		.fine_imag(fine_imag));
	task automatic results();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results
	task automatic check(input logic [33:0] seen, input logic [33:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rdat, output logic [1:0] resp);
		int n;
		@(posedge ref_clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			error_cnt++;
		rdat = avs_readdata;
		resp = avs_response;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus
	task automatic sample(input logic n);
		longint e [4];
		int     k;
		e = '{default: 0};
		for (int i = 0; i < 4; i++) begin
			e[0] += longint'((i + 1) * 1000 * (n ? -1 : 1)) * w[i];
			e[1] += longint'((i + 1) * 1000 * (n ? -1 : 1)) * w[4 + i];
			e[2] += longint'((i + 5) * 1000 * (n ? -1 : 1)) * w[8 + i];
			e[3] += longint'((i + 5) * 1000 * (n ? -1 : 1)) * w[12 + i];
		end
		@(posedge ref_clk);
		neg   <= n;
		start <= 1'b1;
		@(posedge ref_clk);
		start <= 1'b0;
		k = 0;
		do begin
			@(posedge ref_clk);
			#1;
			k++;
		end while (out_valid !== 1'b1 && k < 10);
		check(34'(out_valid), 34'h1);
		check(coarse_imag, 34'(e[0]));
		check(coarse_real, 34'(e[1]));
		check(fine_imag, 34'(e[2]));
		check(fine_real, 34'(e[3]));
	endtask : sample
	initial begin
		#100us;
		error_cnt++;
		results();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		reset <= 1'b0;
		for (int k = 0; k < 16; k++) begin
			bus(1'b0, 8'h12 + 8'(k), 32'h0, rd, rs);
			check({rs, rd}, 34'h0);
		end
		// Low lane only: the high byte keeps its reset value
		be <= 4'h1;
		bus(1'b1, 8'h12, 32'h0000_1234, rd, rs);
		be <= 4'hf;
		bus(1'b0, 8'h12, 32'h0, rd, rs);
		check({rs, rd}, 34'h34);
		// Alternating signs and distinct sizes expose any swapped register
		for (int k = 0; k < 16; k++) begin
			w[k] = 16'((k % 2 ? -1 : 1) * (k * 300 + 100));
			bus(1'b1, 8'h12 + 8'(k), {16'h0000, w[k]}, rd, rs);
			bus(1'b0, 8'h12 + 8'(k), 32'h0, rd, rs);
			check({rs, rd}, {18'h0, w[k]});
		end
		// Addresses just outside the weight map on both sides, then the status write count
		bus(1'b0, 8'h11, 32'h0, rd, rs);
		check({rs, rd}, 34'h2_0000_0000);
		bus(1'b0, 8'h22, 32'h0, rd, rs);
		check({rs, rd}, 34'h2_0000_0000);
		bus(1'b1, 8'h11, 32'h0000_ffff, rd, rs);
		check(34'(rs), 34'h2);
		bus(1'b0, 8'h30, 32'h0, rd, rs);
		check({rs, rd}, 34'h11);
		sample(1'b0);
		sample(1'b1);
		// Unity weight on coarse real channel 1 only
		for (int k = 4; k < 8; k++) begin
			w[k] = (k == 5) ? 16'h4000 : 16'h0000;
			bus(1'b1, 8'h12 + 8'(k), {16'h0000, w[k]}, rd, rs);
			check(34'(rs), 34'h0);
		end
		sample(1'b0);
		// Mid-run reset clears every weight and the write count
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		w = '{default: 16'h0000};
		bus(1'b0, 8'h17, 32'h0, rd, rs);
		check({rs, rd}, 34'h0);
		bus(1'b0, 8'h30, 32'h0, rd, rs);
		check({rs, rd}, 34'h0);
		sample(1'b1);
		results();
	end
endmodule : tb_ccw_weighting
`default_nettype wire
